// file: rtl/fbwp_cfg.svh
// Constants of the flash block write protection logic.
`ifndef FBWP_CFG_SVH
`define FBWP_CFG_SVH

`define FBWP_OP_WRITE_ENABLE_CMD      8'h06
`define FBWP_OP_WRDI      8'h04
`define FBWP_OP_STATUS_WRITE_CMD      8'h01
`define FBWP_OP_RDSR      8'h05
`define FBWP_OP_RDFR      8'h48
`define FBWP_OP_WRFR      8'h42
`define FBWP_OP_CER_A     8'hc7
`define FBWP_OP_CER_B     8'h60
`define FBWP_OP_VOLATILE_READ_PARAM_SET_CMD_NWE  8'hc0
`define FBWP_OP_VOLATILE_BANK_REG_WRITE_CMD_NWE 8'h17
`define FBWP_OP_RSTEN     8'h66
`define FBWP_OP_RST       8'h99
`define FBWP_OP_SUSP      8'h75
`define FBWP_OP_PP        8'h02
`define FBWP_OP_PP4       8'h12
`define FBWP_OP_PPQ       8'h32
`define FBWP_OP_PPQ4      8'h34
`define FBWP_OP_PPQIO     8'h38
`define FBWP_OP_PPQIO4    8'h3e
`define FBWP_OP_SER_A     8'hd7
`define FBWP_OP_SER_B     8'h20
`define FBWP_OP_SER4      8'h21
`define FBWP_OP_BER32     8'h52
`define FBWP_OP_BER32_4   8'h5c
`define FBWP_OP_BER64     8'hd8
`define FBWP_OP_BER64_4   8'hdc

// Status byte layout.
`define FBWP_SR_WIP   0
`define FBWP_SR_WEL   1
`define FBWP_SR_BP0   2
`define FBWP_SR_BP3   5
`define FBWP_SR_QE    6
`define FBWP_SR_STATUS_WRITE_LOCK  7
// Function register bit holding the region select.
`define FBWP_FR_TBS   1

// Address and block geometry.
`define FBWP_SH64     16
`define FBWP_SH256    18
`define FBWP_IDX_W    12
`define FBWP_LVL_ALL  4'hf
`define FBWP_LVL_TOP2 2'h3
`define FBWP_LVL_MAX256 4'hb

// Busy time of an accepted program or erase, in cycles.
`define FBWP_BUSY_CYC 16'h0040

`endif

// file: rtl/fbwp_classify.sv
// Opcode classifier for write protection decisions.
`timescale 1ns/1ps
`include "fbwp_cfg.svh"
module fbwp_classify
   import fbwp_pkg::*;
(
   // Opcode
   input  wire logic [7:0]  opcode,
   // Class and busy-pass flag
   output fbwp_cls_t        cls,
   output logic             busy_ok
);
   always_comb begin
      unique case (opcode)
         `FBWP_OP_PP, `FBWP_OP_PP4, `FBWP_OP_PPQ, `FBWP_OP_PPQ4,
         `FBWP_OP_PPQIO, `FBWP_OP_PPQIO4:
            cls = FBWP_CLS_PROG;
         `FBWP_OP_SER_A, `FBWP_OP_SER_B, `FBWP_OP_SER4, `FBWP_OP_BER32,
         `FBWP_OP_BER32_4, `FBWP_OP_BER64, `FBWP_OP_BER64_4:
            cls = FBWP_CLS_SECT;
         `FBWP_OP_CER_A, `FBWP_OP_CER_B:
            cls = FBWP_CLS_CHIP;
         `FBWP_OP_STATUS_WRITE_CMD:
            cls = FBWP_CLS_STATUS_WRITE_CMD;
         `FBWP_OP_WRFR:
            cls = FBWP_CLS_WRFR;
         `FBWP_OP_VOLATILE_READ_PARAM_SET_CMD_NWE, `FBWP_OP_VOLATILE_BANK_REG_WRITE_CMD_NWE:
            cls = FBWP_CLS_NOWEL;
         default:
            cls = FBWP_CLS_OTHER;
      endcase
      busy_ok = (opcode == `FBWP_OP_RDSR) || (opcode == `FBWP_OP_RDFR) ||
                (opcode == `FBWP_OP_RSTEN) || (opcode == `FBWP_OP_RST) ||
                (opcode == `FBWP_OP_SUSP);
   end
endmodule // fbwp_classify

// file: rtl/fbwp_pkg.sv
// Types of the flash block write protection logic.
package fbwp_pkg;
   typedef enum logic [2:0] {
      FBWP_CLS_OTHER,
      FBWP_CLS_PROG,
      FBWP_CLS_SECT,
      FBWP_CLS_CHIP,
      FBWP_CLS_STATUS_WRITE_CMD,
      FBWP_CLS_WRFR,
      FBWP_CLS_NOWEL
   } fbwp_cls_t;
endpackage

// file: rtl/fbwp_range.sv
// Decoder from protect level and region to a protected block range.
`timescale 1ns/1ps
`include "fbwp_cfg.svh"
module fbwp_range (
   // Protection settings
   input  wire logic [3:0]  level,
   input  wire logic        region_select,
   input  wire logic        big_blocks,
   // Range of protected block indices, inclusive
   output logic             any,
   output logic [11:0]      lo,
   output logic [11:0]      hi
);
   logic [12:0] count;
   logic [12:0] total;

   always_comb begin
      total = big_blocks ? 13'h0400 : 13'h1000;
      if (level == 4'h0) begin
         count = 13'h0000;
      end else if (!big_blocks) begin
         if (level == `FBWP_LVL_ALL) begin
            count = 13'h1000;
         end else if (level == 4'he) begin
            count = 13'h0e00;
         end else if (level == 4'hd) begin
            count = 13'h0c00;
         end else begin
            count = 13'h0001 << (level - 4'h1);
         end
      end else if (level[3:2] == `FBWP_LVL_TOP2 ||
                   level >= `FBWP_LVL_MAX256) begin
         count = 13'h0400;
      end else begin
         count = 13'h0001 << (level - 4'h1);
      end
      any = (count != 13'h0000);
      // Bottom ranges grow up from block zero with the same counts.
      if (region_select) begin
         lo = 12'h000;
         hi = 12'(count - 13'h0001);
      end else begin
         lo = 12'(total - count);
         hi = 12'(total - 13'h0001);
      end
   end
endmodule // fbwp_range

// file: rtl/fbwp_top.sv
// Write protection core of a serial flash device.
//
// Behaviour
// - C0h and 17h need no write enable
// - Program or erase in protected range refused
// - Chip erase only when protect level zero
// - Lock clear: status write always allowed
// - Lock set, pin low, quad enable clear: status frozen
// - Lock set, pin high: status writable
// - Quad enable turns control pins into data
// - 64KB top codes 1-12 protect 2^(n-1)
// - 64KB codes 13,14,15 give 3072,3584,4096
// - 64KB bottom mirrors top from block zero
// - 256KB top codes 1-11 protect 2^(n-1)
// - 256KB bottom starts at block zero
// - 256KB upper bits both set: all blocks
// - Region select one-time programmable to bottom
// - Busy: only status read, function read, reset, suspend
`timescale 1ns/1ps
`include "fbwp_cfg.svh"
module fbwp_top
   import fbwp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Configuration strap
   input  wire logic        big_blocks,
   // Decoded command from the serial front end
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_opcode,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [7:0]  cmd_data,
   // Control pins as seen at the package
   input  wire logic        wp_pin,
   input  wire logic        hold_rst_pin,
   // Command outcome
   output logic             cmd_accept,
   output logic             cmd_reject,
   output logic             array_start,
   // Status and function bits
   output logic [7:0]       status,
   output logic             region_select,
   output logic             op_in_progress,
   output logic             write_enable_latch,
   // Pin role
   output logic             wp_active_low,
   output logic             hold_rst_active_low,
   output logic             data_line_two,
   output logic             data_line_three,
   output logic             quad_pin_enable
);
   import fbwp_pkg::*;

   fbwp_cls_t   cls;
   logic        busy_ok;
   logic        rng_any;
   logic [11:0] rng_lo;
   logic [11:0] rng_hi;
   logic [11:0] blk_idx;
   logic        in_range;
   logic        status_locked;
   logic        go;
   logic        next_accept;
   logic        next_start;
   logic [3:0]  protect_level;
   logic        status_write_lock;
   logic [15:0] busy_cnt;

   fbwp_classify u_cls (
      .opcode  (cmd_opcode),
      .cls     (cls),
      .busy_ok (busy_ok)
   );

   fbwp_range u_rng (
      .level         (protect_level),
      .region_select (region_select),
      .big_blocks    (big_blocks),
      .any           (rng_any),
      .lo            (rng_lo),
      .hi            (rng_hi)
   );

   function automatic logic [11:0] block_of(input logic [31:0] a,
                                            input logic big);
      logic [31:0] s;
      s = big ? (a >> `FBWP_SH256) : (a >> `FBWP_SH64);
      return s[11:0];
   endfunction

   assign blk_idx = block_of(cmd_addr, big_blocks);
   assign in_range = rng_any && blk_idx >= rng_lo &&
                     blk_idx <= rng_hi;
   // The lock only bites while the pin is still a protect input.
   assign status_locked = status_write_lock && !wp_pin &&
                          !quad_pin_enable;
   assign go = cmd_valid && (!op_in_progress || busy_ok);

   always_comb begin
      next_accept = 1'b0;
      next_start  = 1'b0;
      if (go) begin
         unique case (cls)
            FBWP_CLS_PROG, FBWP_CLS_SECT: begin
               next_accept = write_enable_latch && !in_range;
               next_start  = next_accept;
            end
            FBWP_CLS_CHIP: begin
               next_accept = write_enable_latch &&
                             protect_level == 4'h0;
               next_start  = next_accept;
            end
            FBWP_CLS_STATUS_WRITE_CMD: begin
               next_accept = write_enable_latch && !status_locked;
               next_start  = next_accept;
            end
            FBWP_CLS_WRFR: begin
               next_accept = write_enable_latch;
               next_start  = next_accept;
            end
            FBWP_CLS_NOWEL:
               next_accept = 1'b1;
            FBWP_CLS_OTHER:
               next_accept = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_accept  <= 1'b0;
         cmd_reject  <= 1'b0;
         array_start <= 1'b0;
      end else begin
         cmd_accept  <= next_accept;
         cmd_reject  <= cmd_valid && !next_accept;
         array_start <= next_start;
      end
   end

   // Status register bits that the status write may change.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         protect_level     <= 4'h0;
         quad_pin_enable   <= 1'b0;
         status_write_lock <= 1'b0;
      end else if (go && cls == FBWP_CLS_STATUS_WRITE_CMD && next_accept) begin
         protect_level     <= cmd_data[`FBWP_SR_BP3:`FBWP_SR_BP0];
         quad_pin_enable   <= cmd_data[`FBWP_SR_QE];
         status_write_lock <= cmd_data[`FBWP_SR_STATUS_WRITE_LOCK];
      end
   end

   // Region select only ever moves from top to bottom.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         region_select <= 1'b0;
      end else if (go && cls == FBWP_CLS_WRFR && next_accept &&
                   cmd_data[`FBWP_FR_TBS]) begin
         region_select <= 1'b1;
      end
   end

   // Write enable latch: set by its command, cleared when a write starts.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         write_enable_latch <= 1'b0;
      end else if (go && cmd_opcode == `FBWP_OP_WRITE_ENABLE_CMD) begin
         write_enable_latch <= 1'b1;
      end else if (next_start ||
                   (go && cmd_opcode == `FBWP_OP_WRDI)) begin
         write_enable_latch <= 1'b0;
      end
   end

   // Busy timer standing in for the array operation time.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt       <= 16'h0000;
         op_in_progress <= 1'b0;
      end else if (next_start) begin
         busy_cnt       <= `FBWP_BUSY_CYC;
         op_in_progress <= 1'b1;
      end else if (busy_cnt != 16'h0000) begin
         busy_cnt       <= busy_cnt - 16'h0001;
         op_in_progress <= (busy_cnt != 16'h0001);
      end
   end

   always_comb begin
      status                    = 8'h00;
      status[`FBWP_SR_WIP]      = op_in_progress;
      status[`FBWP_SR_WEL]      = write_enable_latch;
      status[`FBWP_SR_BP3:`FBWP_SR_BP0] = protect_level;
      status[`FBWP_SR_QE]       = quad_pin_enable;
      status[`FBWP_SR_STATUS_WRITE_LOCK]     = status_write_lock;
   end

   // Pin roles follow the quad enable bit.
   assign wp_active_low       = !quad_pin_enable && !wp_pin;
   assign hold_rst_active_low = !quad_pin_enable && !hold_rst_pin;
   assign data_line_two       = quad_pin_enable && wp_pin;
   assign data_line_three     = quad_pin_enable && hold_rst_pin;
endmodule // fbwp_top

// file: sim/fbwp_host.sv
// Host controller model issuing decoded commands.
`timescale 1ns/1ps
module fbwp_host (
   // Clock and answer
   input  logic        clk,
   input  logic        cmd_accept,
   input  logic        cmd_reject,
   // Command
   output logic        cmd_valid = 1'b0,
   output logic [7:0]  cmd_opcode = 8'h00,
   output logic [31:0] cmd_addr = 32'h0,
   output logic [7:0]  cmd_data = 8'h00
);
   task automatic send(input logic [7:0] op, input logic [31:0] a,
                       input logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clk);
      // Released lines show junk so stale values are never trusted.
      cmd_valid <= 1'b0;
      cmd_opcode <= ~op;
      cmd_addr <= ~a;
      cmd_data <= ~d;
      #1;
      r = {cmd_accept, cmd_reject};
   endtask
   task automatic wr(input logic [7:0] op, input logic [31:0] a,
                     input logic [7:0] d, output logic [1:0] r);
      send(8'h06, 32'h0, 8'h00, r);
      send(op, a, d, r);
   endtask
endmodule // fbwp_host

// file: sim/fbwp_top_assertions.sv
// Checker of the write protection core.
`timescale 1ns/1ps
module fbwp_chk (
   // Clock and reset
   input logic       clk,
   input logic       sys_rst,
   // Command and outcome
   input logic       cmd_valid,
   input logic [7:0] cmd_opcode,
   input logic       wp_pin,
   input logic       cmd_accept,
   input logic       cmd_reject,
   input logic       array_start,
   // State
   input logic [7:0] status,
   input logic       region_select,
   input logic       data_line_two
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_take(logic [7:0] op);
      cmd_valid && cmd_opcode == op;
   endsequence
   property p_one;
      cmd_valid |=> cmd_accept ^ cmd_reject;
   endproperty
   property p_nwe;
      s_take(8'hc0) ##0 !status[0] |=> cmd_accept;
   endproperty
   property p_wel;
      s_take(8'hd8) ##0 !status[1] |=> cmd_reject;
   endproperty
   property p_chip;
      s_take(8'hc7) ##0 status[5:2] != 4'h0 |=> cmd_reject;
   endproperty
   property p_lock;
      s_take(8'h01) ##0 status[7] && !wp_pin && !status[6]
         |=> cmd_reject ##0 status[7:2] == $past(status[7:2]);
   endproperty
   property p_open;
      s_take(8'h01) ##0 status[1] && !status[0] && (!status[7] || wp_pin)
         |=> cmd_accept ##0 array_start;
   endproperty
   property p_pin;
      data_line_two == (status[6] & wp_pin);
   endproperty
   property p_otp;
      region_select |=> region_select;
   endproperty
   property p_busy;
      s_take(8'h02) ##0 status[0] |=> cmd_reject;
   endproperty
   property p_start;
      array_start |-> status[0] && !status[1];
   endproperty
   a_one: assert property (p_one) else $error("no single answer");
   a_nwe: assert property (p_nwe) else $error("c0 refused");
   a_wel: assert property (p_wel) else $error("erase no wel");
   a_chip: assert property (p_chip) else $error("chip erase");
   a_lock: assert property (p_lock) else $error("lock open");
   a_open: assert property (p_open) else $error("status_write_cmd refused");
   a_pin: assert property (p_pin) else $error("pin role");
   a_otp: assert property (p_otp) else $error("region back");
   a_busy: assert property (p_busy) else $error("busy taken");
   a_start: assert property (p_start) else $error("start state");
endmodule // fbwp_chk
bind fbwp_top fbwp_chk i_fbwp_chk (.clk(clk), .sys_rst(sys_rst),
   .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .wp_pin(wp_pin),
   .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
   .array_start(array_start), .status(status),
   .region_select(region_select), .data_line_two(data_line_two));

// file: sim/fbwp_top_tb.sv
// Self-checking bench of the write protection core.
`timescale 1ns/1ps
module fbwp_top_tb;
   logic        clk = 1'b0;
   logic        sys_rst, big_blocks, wp_pin, hold_rst_pin;
   logic        cmd_valid, cmd_accept, cmd_reject, array_start;
   logic [7:0]  cmd_opcode, cmd_data, status;
   logic [31:0] cmd_addr;
   logic        region_select, op_in_progress, write_enable_latch;
   logic        wp_active_low, hold_rst_active_low, quad_pin_enable;
   logic        data_line_two, data_line_three;
   logic [1:0]  r;
   int          errors = 0, samples_checked = 0, b, n, c;
   always #4 clk = ~clk;
   fbwp_top i_fbwp_top (.clk(clk), .sys_rst(sys_rst),
      .big_blocks(big_blocks), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .wp_pin(wp_pin), .hold_rst_pin(hold_rst_pin),
      .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
      .array_start(array_start), .status(status),
      .region_select(region_select), .op_in_progress(op_in_progress),
      .write_enable_latch(write_enable_latch),
      .wp_active_low(wp_active_low),
      .hold_rst_active_low(hold_rst_active_low),
      .data_line_two(data_line_two), .data_line_three(data_line_three),
      .quad_pin_enable(quad_pin_enable));
   fbwp_host i_fbwp_host (.clk(clk), .cmd_accept(cmd_accept),
      .cmd_reject(cmd_reject), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
   task automatic end_of_test;
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", w, e, s);
      end
   endtask
   task automatic idle;
      for (int i = 0; i < 80 && status[0] !== 1'b0; i++) @(posedge clk);
      #1;
      chk("idle", status[0], 1'b0);
      if (status[0] !== 1'b0) end_of_test;
   endtask
   function automatic int cnt(input logic [3:0] lv, input logic bg);
      int k;
      k = (lv == 4'h0) ? 0 : (lv < 4'hd) ? 1 << (lv - 4'h1) :
          (lv == 4'hd) ? 3072 : (lv == 4'he) ? 3584 : 4096;
      return (bg && k > 1024) ? 1024 : k;
   endfunction
   task automatic pins;
      repeat (4) begin
         @(posedge clk);
         wp_pin <= 1'($urandom);
         hold_rst_pin <= 1'($urandom);
         #1;
         chk("io2", data_line_two, quad_pin_enable & wp_pin);
         chk("io3", data_line_three, quad_pin_enable & hold_rst_pin);
         chk("wpn", wp_active_low, !quad_pin_enable & !wp_pin);
         chk("hldn", hold_rst_active_low,
             !quad_pin_enable & !hold_rst_pin);
      end
   endtask
   initial begin
      void'($urandom(32'hcbfc));
      {sys_rst, big_blocks, wp_pin, hold_rst_pin} = 4'hb;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk("reset", {region_select, status}, 9'h0);
      i_fbwp_host.send(8'hc0, 32'h0, 8'h00, r);
      chk("c0", r, 2'b10);
      i_fbwp_host.send(8'h17, 32'h0, 8'h00, r);
      chk("17", r, 2'b10);
      i_fbwp_host.send(8'hd8, 32'h0, 8'h00, r);
      chk("nowel", r, 2'b01);
      for (int rg = 0; rg < 2; rg++) begin
         for (int bg = 0; bg < 2; bg++) for (int lv = 0; lv < 16; lv++) begin
            @(posedge clk) big_blocks <= bg[0];
            i_fbwp_host.wr(8'h01, 32'h0, {2'b00, lv[3:0], 2'b00}, r);
            chk("status_write_cmd", r, 2'b10);
            idle;
            n = bg ? 1024 : 4096;
            c = cnt(lv[3:0], bg[0]);
            for (int k = 0; k < 3; k++) begin
               b = rg ? c - k : n - c - 1 + k;
               if (k == 2 || b < 0 || b >= n) b = $urandom % n;
               i_fbwp_host.wr(8'hd8, (b << (bg ? 18 : 16)) |
                  ($urandom & (bg ? 32'h3ffff : 32'hffff)), 8'h00, r);
               chk("erase", r, (rg ? b < c : b >= n - c) ? 2'b01 : 2'b10);
               if (r == 2'b10) begin
                  chk("wel", status[1], 1'b0);
                  chk("welo", write_enable_latch, 1'b0);
                  chk("wip", op_in_progress, 1'b1);
                  i_fbwp_host.send(8'h02, 32'h0, 8'h00, r);
                  chk("busy", r, 2'b01);
               end
               idle;
            end
            i_fbwp_host.wr(8'hc7, 32'h0, 8'h00, r);
            chk("chip", r, lv == 0 ? 2'b10 : 2'b01);
            idle;
         end
         i_fbwp_host.wr(8'h42, 32'h0, rg ? 8'h00 : 8'h02, r);
         idle;
         chk("region", region_select, 1'b1);
      end
      @(posedge clk) wp_pin <= 1'b0;
      i_fbwp_host.wr(8'h01, 32'h0, 8'h84, r);
      idle;
      i_fbwp_host.wr(8'h01, 32'h0, 8'h00, r);
      chk("locked", {r, status[7:2]}, 8'h61);
      @(posedge clk) wp_pin <= 1'b1;
      i_fbwp_host.wr(8'h01, 32'h0, 8'h80, r);
      idle;
      chk("unlocked", status[7:2], 6'h20);
      pins;
      // Pins are driven by the bench, never tied, so quad may be set.
      @(posedge clk) wp_pin <= 1'b1;
      i_fbwp_host.wr(8'h01, 32'h0, 8'hc0, r);
      idle;
      chk("quad", quad_pin_enable, 1'b1);
      pins;
      end_of_test;
   end
endmodule // fbwp_top_tb
